// >>> hdl/adc_cycle_pkg.sv
// Shared constants and types for the cycle-serial converter control block.
package adc_cycle_pkg;

  localparam int CLK_MHZ = 250;

  // Times in their own units, then the derived cycle counts.
  localparam real CONV_TIME_MS = 16.6;
  localparam real REF_START_MS = 12.0;
  localparam real POR_TIME_MS = 0.5;
  localparam int CONV_CYCLES = int'(CONV_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int REF_START_CYCLES = int'(REF_START_MS * 1000.0 * CLK_MHZ);
  localparam int POR_CYCLES = int'(POR_TIME_MS * 1000.0 * CLK_MHZ);

  localparam int CNT_W = 24;
  localparam int RESULT_W = 16;
  localparam int PROG_W = 4;
  localparam logic [4:0] LAST_FALL = 5'h10;
  localparam logic [2:0] PROG_LEN = 3'h4;

  // Pin positions inside the synchroniser vector.
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SERIAL_IN = 2;
  localparam int PIN_N = 3;
  localparam logic [PIN_N-1:0] PIN_RST = 3'h3;

  // Register byte offsets.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADDR_SOURCE = 8'h08;

  // Status register field positions.
  localparam int ST_BIT_POR = 0;
  localparam int ST_BIT_CONV = 1;
  localparam int ST_BIT_IDLE = 2;
  localparam int ST_BIT_DATA = 3;
  localparam int ST_BIT_CONV_ON = 4;
  localparam int ST_BIT_REF_ON = 5;
  localparam int ST_BIT_REF_OK = 6;
  localparam int ST_BIT_RATE = 7;
  localparam int ST_BIT_PD = 8;

  // Values after reset.
  localparam logic [RESULT_W-1:0] SOURCE_RST = 16'h0000;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic RATE_RST = 1'b0;
  localparam logic PD_RST = 1'b0;

  typedef enum logic [3:0] {
    ST_POR = 4'h1,
    ST_CONVERT = 4'h2,
    ST_IDLE = 4'h4,
    ST_DATA = 4'h8
  } state_e;

endpackage : adc_cycle_pkg

// >>> hdl/pin_sync.sv
// Two-stage pin synchroniser with one-cycle edge strobes taken from the second stage.
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import adc_cycle_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pins_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Only the second stage feeds the edge detector and the outside.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end
    else
    begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule : pin_sync
`default_nettype wire

// >>> hdl/adc_cycle_ctrl.sv
// Sequencer, result holder and three-wire serial port of the converter.
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1: Drive serial output only while select low.
// RL2: Ignore clock and data while select high.
// RL3: Cycle convert, nap/sleep, data; start converting.
// RL4: Power converter down, hold result after conversion.
// RL5: Conversion runs full length, only reset stops.
// RL6: Wait in nap/sleep until select low.
// RL7: Nap keeps reference powered.
// RL8: Leaving sleep restarts reference, 12ms settle.
// RL9: Sign bit shown on entering data state.
// RL10: Next bit after each falling clock edge.
// RL11: Host samples output on rising clock.
// RL12: Shifted value is latest completed conversion.
// RL13: Capture four input bits on rising edges.
// RL14: Program only when key bits are 1,0.
// RL15: Rate 0 gives 60Hz, 1 gives 30Hz.
// RL16: Powerdown bit selects sleep after next conversion.
// RL17: Last twelve input bits are ignored.
// RL18: Input tied low 60Hz, high 30Hz, no sleep.
// RL19: Sixteenth falling edge ends data, starts conversion.
// RL20: Select rising in data aborts, starts conversion.
// RL21: Power-on reset held 0.5ms, then convert.
// RL22: Host discards first result after power-up.
// RL23: Select low while converting shows busy status.
// RL24: Conversion length counted, result from source register.
// RL25: Variant parameter disables rate bit when differential.
module adc_cycle_ctrl
  import adc_cycle_pkg::*;
#(
  parameter int POR_LEN = POR_CYCLES,
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int REF_LEN = REF_START_CYCLES,
  parameter bit DIFFERENTIAL = 1'b0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic select_n_i,
  input wire logic sck_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  output logic converter_power_o,
  output logic reference_power_o
);

  state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] ref_cnt_q;
  logic ref_on_q;
  logic ref_ok_q;
  logic [RESULT_W-1:0] source_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] shift_q;
  logic [4:0] fall_cnt_q;
  logic [2:0] in_cnt_q;
  logic [PROG_W-2:0] in_word_q;
  logic rate_select_q;
  logic reference_powerdown_q;
  logic serial_out_q;
  logic oe_n_q;
  logic conv_on_q;
  logic ack_q;
  logic [31:0] dat_q;

  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;

  // Last count value of a span that lasts len cycles.
  function automatic logic [CNT_W-1:0] last_of(input int len);
    return CNT_W'(len - 1);
  endfunction : last_of

  pin_sync #(
    .W(PIN_N),
    .RST_VAL(PIN_RST)
  ) u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i({serial_in_i, sck_i, select_n_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  wire sel_low = ~pin_lvl[PIN_CS];
  wire sel_rise = pin_rise[PIN_CS];
  wire sck_rise = pin_rise[PIN_SCK] & sel_low; // RL2
  wire sck_fall = pin_fall[PIN_SCK] & sel_low; // RL2
  wire serial_in_lvl = pin_lvl[PIN_SERIAL_IN];

  wire in_por = (state_q == ST_POR);
  wire in_conv = (state_q == ST_CONVERT);
  wire in_idle = (state_q == ST_IDLE);
  wire in_data = (state_q == ST_DATA);

  // The slow rate doubles the conversion span; the differential variant never slows.
  wire slow = rate_select_q & ~DIFFERENTIAL; // RL25
  wire [CNT_W-1:0] conv_last = slow ? last_of(2 * CONV_LEN) : last_of(CONV_LEN); // RL15
  wire por_done = in_por && (cnt_q == last_of(POR_LEN)); // RL21
  wire conv_done = in_conv && (cnt_q == conv_last); // RL5
  wire start_data = in_idle && sel_low; // RL6
  wire last_fall = sck_fall && (fall_cnt_q == LAST_FALL - 5'h01);
  wire data_end = in_data && (sel_rise || last_fall); // RL19 RL20

  // Fourth captured bit completes the programming word.
  wire prog_take = in_data && sck_rise && (in_cnt_q == PROG_LEN - 3'h1);
  wire [PROG_W-1:0] prog_word = {in_word_q, serial_in_lvl};
  wire key_ok = prog_word[3] & ~prog_word[2]; // RL14
  wire tied_high = (prog_word == 4'hF); // RL18
  wire tied_low = (prog_word == 4'h0); // RL18

  wire [31:0] status_word = {
    23'h000000,
    reference_powerdown_q,
    rate_select_q,
    ref_ok_q,
    ref_on_q,
    conv_on_q,
    in_data,
    in_idle,
    in_conv,
    in_por
  };

  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wb_wr_src = wb_req & wb_we_i & (wb_adr_i == ADDR_SOURCE);
  wire [31:0] rd_word =
    (wb_adr_i == ADDR_STATUS) ? status_word :
    (wb_adr_i == ADDR_RESULT) ? {16'h0000, result_q} :
    (wb_adr_i == ADDR_SOURCE) ? {16'h0000, source_q} :
    32'h00000000;

  // Sequencer. Serial activity never touches the convert state, so a
  // conversion can only be cut short by reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_POR; // RL21
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_POR:
        begin
          cnt_q <= por_done ? '0 : cnt_q + 1'b1;
          if (por_done)
            state_q <= ST_CONVERT; // RL3
        end
        ST_CONVERT:
        begin
          cnt_q <= conv_done ? '0 : cnt_q + 1'b1; // RL24
          if (conv_done)
            state_q <= ST_IDLE; // RL4
        end
        ST_IDLE:
        begin
          if (start_data)
            state_q <= ST_DATA; // RL6
        end
        ST_DATA:
        begin
          if (data_end)
            state_q <= ST_CONVERT; // RL19 RL20
        end
        default:
        begin
          state_q <= ST_POR;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Result capture and the output shifter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_q <= RESULT_RST;
      shift_q <= RESULT_RST;
      fall_cnt_q <= '0;
    end
    else
    begin
      if (conv_done)
        result_q <= source_q; // RL4 RL12 RL24
      if (start_data)
      begin
        shift_q <= result_q; // RL9 RL12
        fall_cnt_q <= '0;
      end
      else if (in_data && sck_fall)
      begin
        shift_q <= {shift_q[RESULT_W-2:0], 1'b0}; // RL10
        fall_cnt_q <= fall_cnt_q + 5'h01;
      end
    end
  end

  // Programming word: only the first four rising edges count; the
  // remaining ones fall through the saturated counter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_cnt_q <= '0;
      in_word_q <= '0;
      rate_select_q <= RATE_RST;
      reference_powerdown_q <= PD_RST;
    end
    else
    begin
      if (start_data)
        in_cnt_q <= '0;
      else if (in_data && sck_rise && (in_cnt_q != PROG_LEN))
      begin
        in_cnt_q <= in_cnt_q + 3'h1; // RL13 RL17
        in_word_q <= prog_word[PROG_W-2:0];
      end
      if (prog_take)
      begin
        if (key_ok)
        begin
          rate_select_q <= prog_word[1]; // RL14 RL15
          reference_powerdown_q <= prog_word[0]; // RL16
        end
        else if (tied_high || tied_low)
        begin
          rate_select_q <= tied_high; // RL18
          reference_powerdown_q <= 1'b0; // RL18
        end
      end
    end
  end

  // Reference power: off only after a conversion with powerdown set, back
  // on when select falls. The settle flag is advisory; the first result
  // after a restart is not held back, the host discards it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_on_q <= 1'b1;
      ref_ok_q <= 1'b0;
      ref_cnt_q <= '0;
    end
    else
    begin
      if (conv_done && reference_powerdown_q)
      begin
        ref_on_q <= 1'b0; // RL16
        ref_ok_q <= 1'b0;
      end
      else if (start_data && !ref_on_q)
      begin
        ref_on_q <= 1'b1; // RL8
        ref_cnt_q <= '0;
      end
      else if (ref_on_q && !ref_ok_q)
      begin
        ref_cnt_q <= ref_cnt_q + 1'b1; // RL8
        if (ref_cnt_q == last_of(REF_LEN))
          ref_ok_q <= 1'b1;
      end
    end
  end

  // Pin outputs, all registered.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_out_q <= 1'b1;
      oe_n_q <= 1'b1;
      conv_on_q <= 1'b0;
    end
    else
    begin
      oe_n_q <= ~sel_low; // RL1
      if (in_data)
        serial_out_q <= shift_q[RESULT_W-1]; // RL9 RL10
      else
        serial_out_q <= in_conv | in_por; // RL23
      conv_on_q <= (in_conv & ~conv_done) | por_done; // RL4 RL7
    end
  end

  // Classic Wishbone slave: one wait state, ack for one cycle, unmapped
  // reads return zero and unmapped writes are dropped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      source_q <= SOURCE_RST;
    end
    else
    begin
      ack_q <= wb_req;
      if (wb_req)
        dat_q <= rd_word;
      if (wb_wr_src && wb_sel_i[0])
        source_q[7:0] <= wb_dat_i[7:0]; // RL24
      if (wb_wr_src && wb_sel_i[1])
        source_q[15:8] <= wb_dat_i[15:8]; // RL24
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign serial_out_o = serial_out_q;
  assign serial_out_oe_n_o = oe_n_q;
  assign converter_power_o = conv_on_q;
  assign reference_power_o = ref_on_q;

endmodule : adc_cycle_ctrl
`default_nettype wire

// >>> verification/adc_cycle_ctrl_sva.sv
// Port-level checks of the converter control block.
`timescale 1ns/100ps
`default_nettype none
module adc_cycle_ctrl_sva
#(
  parameter int POR_LEN = 20
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_n_o,
  input wire logic converter_power_o,
  input wire logic reference_power_o
);
  localparam int POR_MIN = POR_LEN - 2;
  localparam int POR_MAX = POR_LEN + 6;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_off_a: assert property ($rose(select_n_i) |-> ##[1:6] serial_out_oe_n_o)
    else $error("output still driven after deselect");
  oe_on_a: assert property ($fell(select_n_i) |-> ##[1:6] !serial_out_oe_n_o)
    else $error("output not driven after select");
  por_conv_a: assert property ($fell(rst_i) |-> ##[POR_MIN:POR_MAX] converter_power_o)
    else $error("no conversion after power-on reset");
  conv_hold_a: assert property ($rose(converter_power_o) |-> converter_power_o [*8])
    else $error("conversion cut short");
  busy_flag_a: assert property (!serial_out_oe_n_o && converter_power_o
    && $past(converter_power_o, 3) |-> serial_out_o)
    else $error("busy status not shown");
  idle_wait_a: assert property ($fell(converter_power_o) ##1 select_n_i [*8]
    |-> !converter_power_o)
    else $error("converter restarted without select");
  ref_down_a: assert property ($fell(reference_power_o) |-> !converter_power_o)
    else $error("reference off during conversion");
  ref_up_a: assert property ($fell(select_n_i) && !reference_power_o
    |-> ##[1:6] reference_power_o)
    else $error("reference not restarted by select");
  abort_conv_a: assert property ($rose(serial_out_oe_n_o) |-> ##[0:4] converter_power_o)
    else $error("no conversion after transfer end");
  cover property ($fell(converter_power_o));
  cover property ($rose(select_n_i) && !converter_power_o);
  cover property ($fell(reference_power_o));
endmodule : adc_cycle_ctrl_sva
bind adc_cycle_ctrl adc_cycle_ctrl_sva #(.POR_LEN(POR_LEN)) i_sva (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .select_n_i(select_n_i),
  .serial_out_o(serial_out_o),
  .serial_out_oe_n_o(serial_out_oe_n_o),
  .converter_power_o(converter_power_o),
  .reference_power_o(reference_power_o)
);
`default_nettype wire

// >>> verification/serial_host.sv
// Host side of the three-wire serial port.
`timescale 1ns/100ps
`default_nettype none
module serial_host
(
  input wire logic clk_i,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_n_i,
  output logic select_n_o,
  output logic sck_o,
  output logic serial_in_o
);
  logic last_q;
  wire logic line_w;
  // A released line toggles each cycle, so a stale bit can never pass for data.
  assign line_w = serial_out_oe_n_i ? ~last_q : serial_out_i;
  always @(posedge clk_i)
  begin
    last_q <= line_w;
  end
  initial
  begin
    last_q = 1'b0;
    select_n_o = 1'b1;
    sck_o = 1'b0;
    serial_in_o = 1'b0;
  end
  // The clock stands low outside frames; a short count of falls aborts.
  task automatic frame(input logic [3:0] word, input int falls, output logic [15:0] data);
    data = 16'h0000;
    @(posedge clk_i) select_n_o <= 1'b0;
    repeat (12) @(posedge clk_i);
    for (int i = 0; i < falls; i++)
    begin
      serial_in_o <= (i < 4) ? word[3 - i] : ~serial_in_o;
      repeat (20) @(posedge clk_i);
      sck_o <= 1'b1;
      data[15 - i] = line_w;
      repeat (20) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (12) @(posedge clk_i);
    select_n_o <= 1'b1;
    @(posedge clk_i);
  endtask : frame
  task automatic status(output logic busy);
    @(posedge clk_i) select_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    busy = line_w;
    select_n_o <= 1'b1;
    @(posedge clk_i);
  endtask : status
endmodule : serial_host
`default_nettype wire

// >>> verification/adc_cycle_serial_control_bench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module adc_cycle_serial_control_bench;
  import adc_cycle_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdata = 32'h0;
  wire logic [31:0] wb_rdata;
  wire logic wb_ack, sel_n, sck, serial_in, serial_out, oe_n, conv_on, ref_on;
  int errors = 0;
  int checked = 0;
  adc_cycle_ctrl #(.POR_LEN(20), .CONV_LEN(200), .REF_LEN(50), .DIFFERENTIAL(1'b0)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdata), .wb_dat_o(wb_rdata),
    .wb_ack_o(wb_ack), .select_n_i(sel_n), .sck_i(sck), .serial_in_i(serial_in),
    .serial_out_o(serial_out), .serial_out_oe_n_o(oe_n), .converter_power_o(conv_on),
    .reference_power_o(ref_on));
  serial_host i_host (.clk_i(clk_i), .serial_out_i(serial_out), .serial_out_oe_n_i(oe_n),
    .select_n_o(sel_n), .sck_o(sck), .serial_in_o(serial_in));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdata <= wd;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Counts the cycles of one conversion, or of what is left of a running one.
  task automatic conv(output int n);
    n = 0;
    while (conv_on !== 1'b1) @(posedge clk_i);
    while (conv_on === 1'b1)
    begin
      n++;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : conv
  task automatic finish_test;
    $display("errors %0d, checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial
  begin
    logic [31:0] rd;
    logic [15:0] d;
    logic b;
    int n;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reference power", 32'h1, {31'h0, ref_on});
    chk("converter power", 32'h0, {31'h0, conv_on});
    wb(1'b1, ADDR_SOURCE, 32'h0000A5C3, rd);
    wb(1'b1, ADDR_RESULT, 32'h0000FFFF, rd);
    wb(1'b0, 8'h0C, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    wb(1'b0, ADDR_RESULT, 32'h0, rd);
    chk("result after reset", {16'h0000, RESULT_RST}, rd);
    conv(n);
    chk("default rate", 32'h0, {31'h0, n > 300});
    wb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk("status in nap", 32'h64, rd);
    i_host.frame(4'hA, 4, d);
    i_host.status(b);
    chk("busy status", 32'h1, {31'h0, b});
    conv(n);
    chk("rate one", 32'h1, {31'h0, n > 300});
    i_host.frame(4'h9, 16, d);
    chk("shifted result", 32'hA5C3, {16'h0, d});
    wb(1'b0, ADDR_RESULT, 32'h0, rd);
    chk("result register", 32'hA5C3, rd);
    wb(1'b1, ADDR_SOURCE, 32'h00003C5A, rd);
    conv(n);
    chk("rate zero", 32'h0, {31'h0, n > 300});
    chk("reference asleep", 32'h0, {31'h0, ref_on});
    i_host.frame(4'h6, 16, d);
    chk("result after sleep", 32'h3C5A, {16'h0, d});
    chk("reference restarted", 32'h1, {31'h0, ref_on});
    conv(n);
    chk("keyless word", 32'h0, {31'h0, ref_on});
    i_host.frame(4'hF, 16, d);
    conv(n);
    chk("tied high rate", 32'h1, {31'h0, n > 300});
    chk("tied high no sleep", 32'h1, {31'h0, ref_on});
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    finish_test();
  end
endmodule : adc_cycle_serial_control_bench
`default_nettype wire
